//--- logic/stsr_pkg.sv
/*
 * Package for the status byte and service request block: status byte field
 * positions, mask layout, reset values and the serial poll state encoding.
 * Assumes a single system clock and an active low asynchronous reset.
 */
package stsr_pkg;

    // ========================================================================
    // Widths
    // ========================================================================
    localparam int STSR_BYTE_W = 8;
    localparam int STSR_COND_W = 6;
    localparam int STSR_MASK_USED_W = 5;
    localparam int STSR_SYNC_W = 9;

    // ========================================================================
    // Status byte bit positions
    // ========================================================================
    localparam int STSR_BIT_DATA_READY = 0;
    localparam int STSR_BIT_MEAS_DONE = 1;
    localparam int STSR_BIT_ERROR = 2;
    localparam int STSR_BIT_LEVEL = 3;
    localparam int STSR_BIT_LOCAL = 4;
    localparam int STSR_BIT_POWER_ON = 5;
    localparam int STSR_BIT_RQS = 6;
    localparam int STSR_BIT_UNUSED = 7;

    // ========================================================================
    // Synchroniser input lanes
    // ========================================================================
    localparam int STSR_SYN_DATA_READY = 0;
    localparam int STSR_SYN_MEAS_DONE = 1;
    localparam int STSR_SYN_ERROR = 2;
    localparam int STSR_SYN_LEVEL = 3;
    localparam int STSR_SYN_LOCAL = 4;
    localparam int STSR_SYN_SELF_CHECK = 5;
    localparam int STSR_SYN_OVERFLOW = 6;
    localparam int STSR_SYN_NO_ACQUIRE = 7;
    localparam int STSR_SYN_LISTEN = 8;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [7:0] STSR_MASK_RESET = 8'h00;
    localparam logic [7:0] STSR_BYTE_RESET = 8'h00;
    localparam logic [8:0] STSR_SYNC_RESET = 9'h000;

    // ========================================================================
    // Serial poll sequencing
    // ========================================================================
    typedef enum logic [1:0] {
        STSR_POLL_IDLE   = 2'b00,
        STSR_POLL_ANSWER = 2'b01,
        STSR_POLL_HOLD   = 2'b10
    } stsr_poll_type;

endpackage

//--- logic/stsr_sync_if.sv
/*
 * Interface carrying raw asynchronous condition levels into the
 * synchroniser and the cleaned levels back out.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps

interface stsr_sync_if #(
    parameter int W = 9
);
    logic [W-1:0] raw;
    logic [W-1:0] clean;

    modport sync_side (
        input  raw,
        output clean
    );

    modport user_side (
        output raw,
        input  clean
    );
endinterface

//--- logic/stsr_sync.sv
/*
 * Three flip-flop synchroniser bank; a lane's clean level changes only
 * once the second and third stages agree.
 * Assumes raw inputs are asynchronous to the system clock.
 */
`timescale 1ns/1ps

module stsr_sync #(
    parameter int W = 9
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    stsr_sync_if.sync_side    sif
);
    import stsr_pkg::*;

    // ========================================================================
    // Per lane stages
    // ========================================================================
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_lane
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic clean_r;

            // First stage feeds only the second
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end else begin
                    s1_r <= sif.raw[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end

            // Agreement filter rejects single-stage glitches
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    clean_r <= 1'b0;
                end else if (s2_r == s3_r) begin
                    clean_r <= s3_r;
                end
            end

            assign sif.clean[g] = clean_r;
        end
    endgenerate

endmodule

//--- logic/stsr_top.sv
/*
 * Status byte and service request logic of the counter's bus port:
 * condition flags, request enable mask, rising edge request detection,
 * request summary bit, serial poll answer and front panel indicators.
 * Assumes command parsing delivers the mask command and poll strobes on
 * this clock, and that condition levels arrive from asynchronous logic.
 */
`timescale 1ns/1ps

module stsr_top (
    input  wire logic                        CLK_SYS,
    input  wire logic                        RST_N,
    input  wire logic                        SELF_CHECK_DONE,
    input  wire logic                        FRONT_PANEL_CONTROL,
    input  wire logic                        INPUT_LEVEL_COND,
    input  wire logic                        ERROR_COND,
    input  wire logic                        MEAS_COMPLETE,
    input  wire logic                        DATA_READY,
    input  wire logic                        OUTPUT_OVERFLOW,
    input  wire logic                        NO_ACQUIRE,
    input  wire logic                        ADDRESSED_LISTEN,
    input  wire logic                        ADDRESSED_TALK,
    input  wire logic                        REQUEST_ENABLE_COMMAND,
    input  wire logic [stsr_pkg::STSR_BYTE_W-1:0] REQUEST_ENABLE_VALUE,
    input  wire logic                        POLL_REQ,
    input  wire logic                        POLL_ACK,
    output logic                             POLL_VALID,
    output logic [stsr_pkg::STSR_BYTE_W-1:0] CONDITION_SUMMARY_BYTE,
    output logic                             SERVICE_REQUEST,
    output logic                             BUS_CONTROL_INDICATOR,
    output logic                             ADDRESSED_LISTENER_INDICATOR,
    output logic                             ADDRESSED_TALKER_INDICATOR,
    output logic                             REQUEST_INDICATOR
);
    import stsr_pkg::*;

    // ========================================================================
    // Declarations
    // ========================================================================
    logic [STSR_BYTE_W-1:0]      request_enable_mask_r;
    logic                        power_on_r;
    logic [STSR_COND_W-1:0]      cond;
    logic [STSR_MASK_USED_W-1:0] prev_r;
    logic [STSR_MASK_USED_W-1:0] rise;
    logic [STSR_MASK_USED_W-1:0] enabled_rise;
    logic [STSR_MASK_USED_W-1:0] enabled_level;
    logic                        data_ready_blocked;
    logic                        request_event;
    logic                        request_summary_bit_r;
    logic                        request_summary_bit_nxt;
    logic                        poll_returned;
    logic [STSR_BYTE_W-1:0]      live_byte;
    logic [STSR_BYTE_W-1:0]      answer_r;
    logic                        talk_r;
    stsr_poll_type               poll_r;
    stsr_poll_type               poll_nxt;

    stsr_sync_if #(.W(STSR_SYNC_W)) sif ();

    // ========================================================================
    // Input synchronisation
    // ========================================================================
    assign sif.raw[STSR_SYN_DATA_READY]  = DATA_READY;
    assign sif.raw[STSR_SYN_MEAS_DONE]   = MEAS_COMPLETE;
    assign sif.raw[STSR_SYN_ERROR]       = ERROR_COND;
    assign sif.raw[STSR_SYN_LEVEL]       = INPUT_LEVEL_COND;
    assign sif.raw[STSR_SYN_LOCAL]       = FRONT_PANEL_CONTROL;
    assign sif.raw[STSR_SYN_SELF_CHECK]  = SELF_CHECK_DONE;
    assign sif.raw[STSR_SYN_OVERFLOW]    = OUTPUT_OVERFLOW;
    assign sif.raw[STSR_SYN_NO_ACQUIRE]  = NO_ACQUIRE;
    assign sif.raw[STSR_SYN_LISTEN]      = ADDRESSED_LISTEN;

    stsr_sync #(
        .W(STSR_SYNC_W)
    ) u_sync (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .sif   (sif.sync_side)
    );

    // ========================================================================
    // Request enable mask
    // ========================================================================
    // Load binary mask value
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            request_enable_mask_r <= STSR_MASK_RESET;
        end else if (REQUEST_ENABLE_COMMAND) begin
            request_enable_mask_r <= REQUEST_ENABLE_VALUE;
        end
    end

    // ========================================================================
    // Condition flags
    // ========================================================================
    // Power-on after self check
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            power_on_r <= 1'b0;
        end else if (sif.clean[STSR_SYN_SELF_CHECK]) begin
            power_on_r <= 1'b1;
        end
    end

    always_comb begin
        cond = '0;
        cond[STSR_BIT_DATA_READY] = sif.clean[STSR_SYN_DATA_READY];
        cond[STSR_BIT_MEAS_DONE]  = sif.clean[STSR_SYN_MEAS_DONE];
        cond[STSR_BIT_ERROR]      = sif.clean[STSR_SYN_ERROR];
        cond[STSR_BIT_LEVEL]      = sif.clean[STSR_SYN_LEVEL];
        cond[STSR_BIT_LOCAL]      = sif.clean[STSR_SYN_LOCAL];
        cond[STSR_BIT_POWER_ON]   = power_on_r;
    end

    // ========================================================================
    // Rising edge detection
    // ========================================================================
    // Previous levels track only the maskable conditions
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            prev_r <= '0;
        end else begin
            prev_r <= cond[STSR_MASK_USED_W-1:0];
        end
    end

    assign rise = cond[STSR_MASK_USED_W-1:0] & ~prev_r;

    assign data_ready_blocked = sif.clean[STSR_SYN_OVERFLOW] |
                                sif.clean[STSR_SYN_NO_ACQUIRE];

    always_comb begin
        enabled_rise = rise & request_enable_mask_r[STSR_MASK_USED_W-1:0];
        enabled_level = cond[STSR_MASK_USED_W-1:0] &
                        request_enable_mask_r[STSR_MASK_USED_W-1:0];
        if (data_ready_blocked) begin
            enabled_rise[STSR_BIT_DATA_READY] = 1'b0;
        end
    end

    assign request_event = |enabled_rise;

    // ========================================================================
    // Request summary bit and service request
    // ========================================================================
    // Summary set with request
    // Cleared by returned poll or when no enabled condition level is set
    // A new rise in the poll's own cycle wins, so no request is lost
    always_comb begin
        request_summary_bit_nxt = request_summary_bit_r;
        if (poll_returned || (enabled_level == '0)) begin
            request_summary_bit_nxt = 1'b0;
        end
        if (request_event) begin
            request_summary_bit_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            request_summary_bit_r <= 1'b0;
        end else begin
            request_summary_bit_r <= request_summary_bit_nxt;
        end
    end

    // ========================================================================
    // Status byte
    // ========================================================================
    // Top bit always zero
    always_comb begin
        live_byte = STSR_BYTE_RESET;
        live_byte[STSR_COND_W-1:0] = cond;
        live_byte[STSR_BIT_RQS] = request_summary_bit_r;
        live_byte[STSR_BIT_UNUSED] = 1'b0;
    end

    // ========================================================================
    // Serial poll answer
    // ========================================================================
    // Poll taken only in the idle state
    always_comb begin
        poll_nxt = poll_r;
        case (poll_r)
            STSR_POLL_IDLE: begin
                if (POLL_REQ) begin
                    poll_nxt = STSR_POLL_ANSWER;
                end
            end
            STSR_POLL_ANSWER: begin
                poll_nxt = STSR_POLL_HOLD;
            end
            STSR_POLL_HOLD: begin
                if (POLL_ACK) begin
                    poll_nxt = STSR_POLL_IDLE;
                end
            end
            default: begin
                poll_nxt = STSR_POLL_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            poll_r <= STSR_POLL_IDLE;
        end else begin
            poll_r <= poll_nxt;
        end
    end

    // Snapshot keeps the byte stable while the controller reads it
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            answer_r <= STSR_BYTE_RESET;
        end else if ((poll_r == STSR_POLL_IDLE) && POLL_REQ) begin
            answer_r <= live_byte;
        end
    end

    // A poll releases the request only after the controller has the byte
    assign poll_returned = (poll_r == STSR_POLL_HOLD) && POLL_ACK;

    assign POLL_VALID = (poll_r == STSR_POLL_HOLD);
    assign CONDITION_SUMMARY_BYTE = answer_r;

    // ========================================================================
    // Indicators
    // ========================================================================
    // Talk state comes from same-clock bus logic, so no synchroniser
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            talk_r <= 1'b0;
        end else begin
            talk_r <= ADDRESSED_TALK;
        end
    end

    assign BUS_CONTROL_INDICATOR = ~sif.clean[STSR_SYN_LOCAL];
    assign REQUEST_INDICATOR = request_summary_bit_r;
    assign SERVICE_REQUEST = request_summary_bit_r;

    assign ADDRESSED_LISTENER_INDICATOR = sif.clean[STSR_SYN_LISTEN];
    assign ADDRESSED_TALKER_INDICATOR = talk_r;

endmodule

//--- sim/stsr_ctl_model.sv
/* Bus controller model: serial poll of the status byte, prompt or slow ack.
   Assumes it shares the system clock and reset with stsr_top. */
`timescale 1ns/1ps

module stsr_ctl_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [3:0] slow,
    input  wire logic       poll_valid,
    input  wire logic [7:0] poll_byte,
    output logic            poll_req,
    output logic            poll_ack,
    output logic            done,
    output logic [7:0]      byte_seen
);
    logic [1:0] st_r;
    logic [3:0] cnt_r;

    // ========================================================================
    // Poll sequence
    // ========================================================================
    // poll, then read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r      <= 2'h0;
            cnt_r     <= 4'h0;
            poll_req  <= 1'b0;
            poll_ack  <= 1'b0;
            done      <= 1'b0;
            byte_seen <= 8'h00;
        end else begin
            done <= 1'b0;
            case (st_r)
                2'h0: if (go) begin
                    poll_req <= 1'b1;
                    st_r     <= 2'h1;
                end
                2'h1: begin
                    poll_req <= 1'b0;
                    cnt_r    <= 4'h0;
                    if (poll_valid) st_r <= 2'h2;
                end
                2'h2: begin
                    cnt_r <= cnt_r + 4'h1;
                    // Slow controllers hold off the ack
                    if (cnt_r >= slow) begin
                        poll_ack <= 1'b1;
                        st_r     <= 2'h3;
                    end
                end
                default: if (poll_valid) begin
                    byte_seen <= poll_byte;
                    poll_ack  <= 1'b0;
                    done      <= 1'b1;
                    st_r      <= 2'h0;
                end
            endcase
        end
    end
endmodule

//--- sim/stsr_checker.sv
/* Checker on the ports of stsr_top: poll answer, request and indicators.
   Assumes one clock and the active low asynchronous reset of the block. */
`timescale 1ns/1ps

module stsr_checker (
    input wire logic                             CLK_SYS,
    input wire logic                             RST_N,
    input wire logic                             FRONT_PANEL_CONTROL,
    input wire logic                             ADDRESSED_LISTEN,
    input wire logic                             ADDRESSED_TALK,
    input wire logic                             REQUEST_ENABLE_COMMAND,
    input wire logic [stsr_pkg::STSR_BYTE_W-1:0] REQUEST_ENABLE_VALUE,
    input wire logic                             POLL_REQ,
    input wire logic                             POLL_ACK,
    input wire logic                             POLL_VALID,
    input wire logic [stsr_pkg::STSR_BYTE_W-1:0] CONDITION_SUMMARY_BYTE,
    input wire logic                             SERVICE_REQUEST,
    input wire logic                             BUS_CONTROL_INDICATOR,
    input wire logic                             ADDRESSED_LISTENER_INDICATOR,
    input wire logic                             ADDRESSED_TALKER_INDICATOR,
    input wire logic                             REQUEST_INDICATOR
);
    import stsr_pkg::*;
    logic [4:0] mask_r;

    // ========================================================================
    // Mask shadow; only the gating bits matter
    // ========================================================================
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) mask_r <= 5'h00;
        else if (REQUEST_ENABLE_COMMAND) mask_r <= REQUEST_ENABLE_VALUE[4:0];
    end

    // ========================================================================
    // Properties
    // ========================================================================
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    sequence poll_take_s; POLL_REQ && !POLL_VALID; endsequence
    sequence poll_ans_s; ##1 !POLL_VALID ##1 POLL_VALID; endsequence

    top_bit_zero_a: assert property (POLL_VALID |-> !CONDITION_SUMMARY_BYTE[STSR_BIT_UNUSED])
        else $error("status top bit set");
    poll_answer_a: assert property (poll_take_s |-> poll_ans_s)
        else $error("poll answer not two cycles after request");
    byte_hold_a: assert property (POLL_VALID && !POLL_ACK |=> POLL_VALID
        && $stable(CONDITION_SUMMARY_BYTE)) else $error("poll byte dropped before ack");
    ack_release_a: assert property (POLL_VALID && POLL_ACK |=>
        !POLL_VALID && !SERVICE_REQUEST) else $error("request kept after poll ack");
    summary_gate_a: assert property (POLL_VALID && CONDITION_SUMMARY_BYTE[STSR_BIT_RQS]
        |-> (CONDITION_SUMMARY_BYTE[4:0] & mask_r) != 5'h00) else $error("summary bit ungated");
    req_mask_a: assert property ($rose(SERVICE_REQUEST) |-> mask_r != 5'h00)
        else $error("request with empty mask");
    req_ind_a: assert property (REQUEST_INDICATOR == SERVICE_REQUEST)
        else $error("request indicator differs");
    // Reset must be seen released first, else the reset-held flop is compared to a live input
    talk_ind_a: assert property (RST_N |=> ADDRESSED_TALKER_INDICATOR == $past(ADDRESSED_TALK))
        else $error("talker indicator lag wrong");
    listen_ind_a: assert property ($stable(ADDRESSED_LISTEN) [*6] |->
        ADDRESSED_LISTENER_INDICATOR == ADDRESSED_LISTEN) else $error("listener indicator wrong");
    remote_ind_a: assert property ($stable(FRONT_PANEL_CONTROL) [*6] |->
        BUS_CONTROL_INDICATOR == !FRONT_PANEL_CONTROL) else $error("remote indicator wrong");
endmodule

bind stsr_top stsr_checker chk_u (.*);

//--- sim/stsr_top_tb.sv
/* Testbench for stsr_top: conditions, mask commands, polls, indicators.
   Assumes stsr_ctl_model answers the poll side and the checker is bound. */
`timescale 1ns/1ps

module stsr_top_tb;
    logic       clk, rst_n, self_chk, listen, talk, cmd, go, req, ack, valid, done;
    logic       srq, bus_ind, lsn_ind, tlk_ind, rq_ind;
    logic [6:0] cond;
    logic [3:0] slow;
    logic [7:0] val, sb, seen, b;
    int         failures = 0;
    int         checks = 0;

    // Condition lanes: noacq, overflow, local, level, error, meas, data
    stsr_top dut_u (
        .CLK_SYS(clk), .RST_N(rst_n), .SELF_CHECK_DONE(self_chk),
        .FRONT_PANEL_CONTROL(cond[4]), .INPUT_LEVEL_COND(cond[3]), .ERROR_COND(cond[2]),
        .MEAS_COMPLETE(cond[1]), .DATA_READY(cond[0]), .OUTPUT_OVERFLOW(cond[5]),
        .NO_ACQUIRE(cond[6]), .ADDRESSED_LISTEN(listen), .ADDRESSED_TALK(talk),
        .REQUEST_ENABLE_COMMAND(cmd), .REQUEST_ENABLE_VALUE(val), .POLL_REQ(req),
        .POLL_ACK(ack), .POLL_VALID(valid), .CONDITION_SUMMARY_BYTE(sb),
        .SERVICE_REQUEST(srq), .BUS_CONTROL_INDICATOR(bus_ind),
        .ADDRESSED_LISTENER_INDICATOR(lsn_ind), .ADDRESSED_TALKER_INDICATOR(tlk_ind),
        .REQUEST_INDICATOR(rq_ind)
    );
    stsr_ctl_model ctl_u (
        .clk(clk), .rst_n(rst_n), .go(go), .slow(slow), .poll_valid(valid),
        .poll_byte(sb), .poll_req(req), .poll_ack(ack), .done(done), .byte_seen(seen)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Eight cycles covers the input synchroniser and the request edge
    task automatic set_cond(input logic [6:0] c);
        @(posedge clk);
        cond <= c;
        tick(8);
    endtask
    task automatic load_mask(input logic [7:0] m);
        @(posedge clk);
        cmd <= 1'b1;
        val <= m;
        @(posedge clk);
        cmd <= 1'b0;
    endtask
    task automatic poll(input logic [3:0] d);
        int n;
        n = 0;
        @(posedge clk);
        go   <= 1'b1;
        slow <= d;
        @(posedge clk);
        go <= 1'b0;
        while (done !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk(8'(n < 40), 8'h01);
        b = seen;
        tick(2);
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #100us;
        failures++;
        end_sim();
    end

    // ========================================================================
    // Sequence
    // ========================================================================
    initial begin
        {rst_n, self_chk, listen, talk, cmd, go} = 6'h00;
        {cond, slow, val} = 19'h00000;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        chk(8'(bus_ind), 8'h01);
        poll(4'h0);
        chk(b, 8'h00);
        @(posedge clk);
        self_chk <= 1'b1;
        tick(8);
        @(posedge clk);
        self_chk <= 1'b0;
        tick(8);
        poll(4'h0);
        chk(b, 8'h20);
        for (int i = 0; i < 5; i++) begin
            set_cond(7'h01 << i);
            chk(8'(srq), 8'h00);
            chk(8'(bus_ind), 8'(i != 4));
            poll(4'h0);
            chk(b, 8'h20 | (8'h01 << i));
            set_cond(7'h00);
        end
        load_mask(8'he0);
        set_cond(7'h1f);
        chk(8'(srq), 8'h00);
        set_cond(7'h00);
        load_mask(8'h0d);
        set_cond(7'h04);
        chk(8'({srq, rq_ind}), 8'h03);
        poll(4'h3);
        chk(b, 8'h64);
        chk(8'(srq), 8'h00);
        set_cond(7'h14);
        chk(8'(srq), 8'h00);
        poll(4'h0);
        chk(b, 8'h34);
        set_cond(7'h20);
        set_cond(7'h21);
        chk(8'(srq), 8'h00);
        set_cond(7'h40);
        set_cond(7'h41);
        chk(8'(srq), 8'h00);
        set_cond(7'h00);
        set_cond(7'h01);
        chk(8'(srq), 8'h01);
        poll(4'h5);
        chk(b, 8'h61);
        set_cond(7'h00);
        set_cond(7'h06);
        poll(4'h0);
        chk(b, 8'h66);
        // Summary must drop once no enabled condition is left, even without a poll
        set_cond(7'h02);
        set_cond(7'h06);
        chk(8'(srq), 8'h01);
        set_cond(7'h02);
        chk(8'(srq), 8'h00);
        @(posedge clk);
        talk   <= 1'b1;
        listen <= 1'b1;
        tick(8);
        chk(8'({lsn_ind, tlk_ind}), 8'h03);
        // Reset in mid-run clears the mask and the power-on flag
        @(posedge clk);
        rst_n <= 1'b0;
        tick(2);
        @(posedge clk);
        rst_n <= 1'b1;
        set_cond(7'h04);
        chk(8'(srq), 8'h00);
        poll(4'h0);
        chk(b, 8'h04);
        end_sim();
    end
endmodule
